// File: core/meas_err_map.vh
/*
 * constants for the measurement error classifier: indication
 * codes, judgment codes and store sizing.
 * assumes inclusion by bare name from the design, checker and bench files.
 */
`ifndef MEAS_ERR_MAP_VH
`define MEAS_ERR_MAP_VH

// -----------------------------------------------------------------------------
// indication codes shown on the display
// -----------------------------------------------------------------------------
`define IND_W               3
`define IND_NONE            3'h0
`define IND_TC_FAULT        3'h1
`define IND_POS_OVR         3'h2
`define IND_NEG_OVR         3'h3
`define IND_CONTACT         3'h4
`define IND_NO_DATA         3'h5

// -----------------------------------------------------------------------------
// judgment codes
// -----------------------------------------------------------------------------
`define JUDGE_W             2
`define JUDGE_NONE          2'h0
`define JUDGE_IN            2'h1
`define JUDGE_HI            2'h2
`define JUDGE_LO            2'h3

// -----------------------------------------------------------------------------
// store sizing
// -----------------------------------------------------------------------------
`define STORE_DEPTH         5000
`define STORE_AW            13

`endif

// File: core/measurement_error_priority.v
/*
 * measurement error priority classifier with measured-value ring store.
 * classifies each completed measurement, drives indication and the external
 * control port fault/above/under lines, and records values for trend display.
 * assumes all inputs are synchronous to clk and meas_done is a one-cycle pulse.
 */
`timescale 1ns/10ps
`include "meas_err_map.vh"

// Functional notes
// - errors checked in order: tc fault, +overrange, -overrange, contact, no data
// - only the highest-priority error is shown and driven, lower ones suppressed
// - value beyond selected range limits flags positive or negative overrange
// - converter input overrange at any time during measurement flags overrange
// - positive overrange forces above-limit judgment, negative under-limit (above-limit in abs mode); in if only the far limit is on
// - temperature beyond its range when the measurement completes flags positive overrange
// - with contact checking enabled, hi-lo contact is tested each measurement
// - poor contact shows contact indication and raises the fault line
// - no comparator or band judgments while contact fault is indicated
// - after condition change, no-data is shown until a new measurement completes with an error, or else until a second one completes
// - without temperature sensor, temperature is not measured, sensor-absent shown
// - measured values held in a 5000-entry store feeding the trend view
// - when full, each new value overwrites the oldest entry
// - clear command from trend view empties the store
// - enabled judgment is presented alongside the measured value
// - store also erased on reset, panel load, remote clear, start, power-off
module measurement_error_priority #(
	parameter DW    = 32,
	parameter DEPTH = `STORE_DEPTH,
	parameter AW    = `STORE_AW
) (
	input  wire                 clk,
	input  wire                 srst,
	input  wire                 meas_done,
	input  wire signed [DW-1:0] meas_value,
	input  wire signed [DW-1:0] range_upper,
	input  wire signed [DW-1:0] range_lower,
	input  wire                 adc_pos_overflow,
	input  wire                 adc_neg_overflow,
	input  wire                 meas_start,
	input  wire                 temp_sensor_present,
	input  wire                 temp_over_range,
	input  wire signed [DW-1:0] temp_value,
	input  wire                 temp_compensation_fault,
	input  wire                 contact_check_en,
	input  wire                 contact_ok,
	input  wire                 cond_changed,
	input  wire                 comparator_en,
	input  wire                 multi_band_sort_en,
	input  wire                 abs_judge_en,
	input  wire                 upper_limit_en,
	input  wire                 lower_limit_en,
	input  wire signed [DW-1:0] upper_limit,
	input  wire signed [DW-1:0] lower_limit,
	input  wire                 clear_record_key,
	input  wire                 panel_load,
	input  wire                 remote_clear,
	input  wire                 immediate_start,
	input  wire                 power_off,
	input  wire [AW-1:0]        rd_index,
	output reg  [`IND_W-1:0]    indication_q,
	output reg                  fault_out_q,
	output reg                  above_limit_output_q,
	output reg                  under_limit_output_q,
	output reg  [`JUDGE_W-1:0]  judgment_q,
	output reg                  judgment_valid_q,
	output reg                  multi_band_sort_valid_q,
	output reg  signed [DW-1:0] value_out_q,
	output reg  signed [DW-1:0] temp_out_q,
	output reg                  temp_absent_q,
	output reg  [AW-1:0]        store_count_q,
	output reg  signed [DW-1:0] rd_data_q
);

	// -------------------------------------------------------------------------
	// measurement phase
	// -------------------------------------------------------------------------
	localparam PH_IDLE = 2'b01;
	localparam PH_RUN  = 2'b10;

	reg [1:0] phase_q;
	reg [1:0] phase_d;

	// overflow outside a measurement is ignored, so a stray excursion
	// between readings cannot condemn the next one
	always @* begin
		phase_d = phase_q;
		case (phase_q)
			PH_IDLE: begin
				if (meas_start && !meas_done)
					phase_d = PH_RUN;
			end
			PH_RUN: begin
				if (meas_done || cond_changed)
					phase_d = PH_IDLE;
			end
			default: begin
				phase_d = PH_IDLE;
			end
		endcase
	end

	always @(posedge clk) begin
		if (srst)
			phase_q <= PH_IDLE;
		else
			phase_q <= phase_d;
	end

	wire in_meas = (phase_q == PH_RUN) | meas_start;

	// -------------------------------------------------------------------------
	// overrange latched across a measurement
	// -------------------------------------------------------------------------
	reg pos_seen_q;
	reg neg_seen_q;
	reg no_data_q;

	// the converter can saturate mid-integration and still settle in range,
	// so any excursion between start and done is remembered
	always @(posedge clk) begin
		if (srst || meas_done) begin
			pos_seen_q <= 1'b0;
			neg_seen_q <= 1'b0;
		end else begin
			// an excursion in the start cycle belongs to the new measurement, so set wins
			if (adc_pos_overflow && in_meas)
				pos_seen_q <= 1'b1;
			else if (meas_start)
				pos_seen_q <= 1'b0;
			if (adc_neg_overflow && in_meas)
				neg_seen_q <= 1'b1;
			else if (meas_start)
				neg_seen_q <= 1'b0;
		end
	end

	// -------------------------------------------------------------------------
	// classification
	// -------------------------------------------------------------------------
	wire temp_ovr    = temp_sensor_present & temp_over_range;
	wire pos_ovr     = (meas_value > range_upper) | pos_seen_q | adc_pos_overflow | temp_ovr;
	wire neg_ovr     = (meas_value < range_lower) | neg_seen_q | adc_neg_overflow;
	wire contact_bad = contact_check_en & ~contact_ok;
	wire judge_en    = comparator_en | multi_band_sort_en;

	// absolute value of a reading for abs judgment mode
	function signed [DW-1:0] mag;
		input signed [DW-1:0] v;
		begin
			mag = (v < 0) ? -v : v;
		end
	endfunction

	// comparator judgment for an in-range value
	function [`JUDGE_W-1:0] compare;
		input signed [DW-1:0] v;
		input                 up_en;
		input                 lo_en;
		input signed [DW-1:0] up;
		input signed [DW-1:0] lo;
		begin
			if (up_en && v > up)
				compare = `JUDGE_HI;
			else if (lo_en && v < lo)
				compare = `JUDGE_LO;
			else
				compare = `JUDGE_IN;
		end
	endfunction

	// judgment forced by an overrange; a one-sided limit on the far side reads as in
	function [`JUDGE_W-1:0] ovr_judge;
		input toward_upper;
		input up_en;
		input lo_en;
		begin
			if (toward_upper)
				ovr_judge = (lo_en && !up_en) ? `JUDGE_IN : `JUDGE_HI;
			else
				ovr_judge = (up_en && !lo_en) ? `JUDGE_IN : `JUDGE_LO;
		end
	endfunction

	reg [`IND_W-1:0]   ind_d;
	reg [`JUDGE_W-1:0] judge_d;
	reg                jvalid_d;
	reg                err_d;

	always @* begin
		ind_d    = `IND_NONE;
		judge_d  = `JUDGE_NONE;
		jvalid_d = 1'b0;
		err_d    = 1'b0;
		// first match wins; lower-priority conditions are never looked at
		if (temp_compensation_fault) begin
			ind_d = `IND_TC_FAULT;
			err_d = 1'b1;
		end else if (pos_ovr) begin
			ind_d    = `IND_POS_OVR;
			jvalid_d = judge_en;
			judge_d  = ovr_judge(1'b1, upper_limit_en, lower_limit_en);
		end else if (neg_ovr) begin
			ind_d    = `IND_NEG_OVR;
			jvalid_d = judge_en;
			judge_d  = ovr_judge(abs_judge_en, upper_limit_en, lower_limit_en);
		end else if (contact_bad) begin
			ind_d = `IND_CONTACT;
			err_d = 1'b1;
		end else if (no_data_q) begin
			ind_d = `IND_NO_DATA;
		end else begin
			jvalid_d = judge_en;
			judge_d  = compare(abs_judge_en ? mag(meas_value) : meas_value,
				upper_limit_en, lower_limit_en, upper_limit, lower_limit);
		end
	end

	// the above/under port lines follow the comparator only; band sorting drives no line here
	wire above_d = comparator_en & jvalid_d & (judge_d == `JUDGE_HI);
	wire under_d = comparator_en & jvalid_d & (judge_d == `JUDGE_LO);

	// -------------------------------------------------------------------------
	// outputs, updated per completed measurement or condition change; sensor-absent every cycle
	// -------------------------------------------------------------------------
	always @(posedge clk) begin
		if (srst) begin
			no_data_q               <= 1'b1;
			indication_q            <= `IND_NO_DATA;
			fault_out_q             <= 1'b0;
			above_limit_output_q    <= 1'b0;
			under_limit_output_q    <= 1'b0;
			judgment_q              <= `JUDGE_NONE;
			judgment_valid_q        <= 1'b0;
			multi_band_sort_valid_q <= 1'b0;
			value_out_q             <= {DW{1'b0}};
			temp_out_q              <= {DW{1'b0}};
			temp_absent_q           <= 1'b1;
		end else if (cond_changed) begin
			// a change in the same cycle as completion discards that result
			no_data_q               <= 1'b1;
			indication_q            <= `IND_NO_DATA;
			fault_out_q             <= 1'b0;
			above_limit_output_q    <= 1'b0;
			under_limit_output_q    <= 1'b0;
			judgment_q              <= `JUDGE_NONE;
			judgment_valid_q        <= 1'b0;
			multi_band_sort_valid_q <= 1'b0;
			temp_absent_q           <= ~temp_sensor_present;
		end else if (meas_done) begin
			no_data_q               <= 1'b0;
			indication_q            <= ind_d;
			fault_out_q             <= err_d;
			above_limit_output_q    <= above_d;
			under_limit_output_q    <= under_d;
			judgment_q              <= jvalid_d ? judge_d : `JUDGE_NONE;
			judgment_valid_q        <= jvalid_d & comparator_en;
			multi_band_sort_valid_q <= jvalid_d & multi_band_sort_en;
			value_out_q             <= meas_value;
			temp_absent_q           <= ~temp_sensor_present;
			if (temp_sensor_present)
				temp_out_q <= temp_value;
		end else begin
			temp_absent_q <= ~temp_sensor_present;
		end
	end

	// -------------------------------------------------------------------------
	// measured-value ring store
	// -------------------------------------------------------------------------
	reg signed [DW-1:0] store_mem [0:DEPTH-1];
	reg [AW-1:0]        wr_ptr_q;
	reg [AW-1:0]        rd_addr;
	wire                erase = clear_record_key | panel_load | remote_clear | immediate_start | power_off;
	wire [AW-1:0]       last_idx = DEPTH[AW-1:0] - 1'b1;
	wire                store_full = (store_count_q == DEPTH[AW-1:0]);
	// the sum carries one extra bit so the wrap test cannot alias
	wire [AW:0]         ring_sum = {1'b0, wr_ptr_q} + {1'b0, rd_index};

	always @* begin
		// index 0 is the oldest entry held
		if (store_full && ring_sum >= DEPTH)
			rd_addr = ring_sum[AW-1:0] - DEPTH[AW-1:0];
		else if (store_full)
			rd_addr = wr_ptr_q + rd_index;
		else
			rd_addr = rd_index;
	end

	always @(posedge clk) begin
		if (srst || erase) begin
			wr_ptr_q      <= {AW{1'b0}};
			store_count_q <= {AW{1'b0}};
		end else if (meas_done && !cond_changed) begin
			wr_ptr_q <= (wr_ptr_q == last_idx) ? {AW{1'b0}} : wr_ptr_q + 1'b1;
			if (!store_full)
				store_count_q <= store_count_q + 1'b1;
		end
	end

	always @(posedge clk) begin
		if (meas_done && !cond_changed && !srst && !erase)
			store_mem[wr_ptr_q] <= meas_value;
		rd_data_q <= store_mem[rd_addr];
	end

endmodule

// File: verification/mep_sva.sv
/*
 * checker for the error classifier outputs and store count.
 * assumes it is bound onto measurement_error_priority and sees only its ports.
 */
`timescale 1ns/10ps
`include "meas_err_map.vh"
module mep_sva #(
	parameter DW = 32,
	parameter AW = 13
) (
	input wire                 clk,
	input wire                 srst,
	input wire                 meas_done,
	input wire                 cond_changed,
	input wire signed [DW-1:0] meas_value,
	input wire signed [DW-1:0] range_upper,
	input wire                 temp_compensation_fault,
	input wire                 comparator_en,
	input wire                 upper_limit_en,
	input wire                 clear_record_key,
	input wire                 panel_load,
	input wire                 remote_clear,
	input wire                 immediate_start,
	input wire                 power_off,
	input wire [2:0]           indication_q,
	input wire                 fault_out_q,
	input wire                 above_limit_output_q,
	input wire                 under_limit_output_q,
	input wire                 judgment_valid_q,
	input wire                 multi_band_sort_valid_q,
	input wire [AW-1:0]        store_count_q
);
// ----
// properties
// ----
default clocking @(posedge clk); endclocking
default disable iff (srst);
wire erase = clear_record_key | panel_load | remote_clear | immediate_start | power_off;
sequence s_take; meas_done && !cond_changed; endsequence
sequence s_pos; s_take ##0 (!temp_compensation_fault && meas_value > range_upper); endsequence
a_tc_first: assert property (s_take ##0 temp_compensation_fault |=>
	indication_q == `IND_TC_FAULT && fault_out_q) else $error("tc fault not reported");
a_pos_over: assert property (s_pos |=> indication_q == `IND_POS_OVR && !fault_out_q)
	else $error("positive overrange missed");
a_pos_line: assert property (s_pos ##0 (comparator_en && upper_limit_en) |=> above_limit_output_q)
	else $error("above line missing on overrange");
a_one_line: assert property ($onehot0({fault_out_q, above_limit_output_q, under_limit_output_q}))
	else $error("more than one port line raised");
a_contact_mute: assert property (indication_q == `IND_CONTACT |->
	fault_out_q && !judgment_valid_q && !multi_band_sort_valid_q) else $error("judgment during contact fault");
a_no_data: assert property (cond_changed |=> indication_q == `IND_NO_DATA && !judgment_valid_q)
	else $error("no-data not shown");
a_store_inc: assert property (s_take ##0 (!erase && store_count_q < `STORE_DEPTH) |=>
	store_count_q == $past(store_count_q) + 1'b1) else $error("store count not advanced");
a_store_sat: assert property (s_take ##0 (!erase && store_count_q == `STORE_DEPTH) |=>
	$stable(store_count_q)) else $error("full store count moved");
a_store_clr: assert property (erase |=> store_count_q == 0) else $error("store not erased");
endmodule
bind measurement_error_priority mep_sva #(.DW(DW), .AW(AW)) mep_sva_i (.clk, .srst, .meas_done,
	.cond_changed, .meas_value, .range_upper, .temp_compensation_fault, .comparator_en, .upper_limit_en,
	.clear_record_key, .panel_load, .remote_clear, .immediate_start, .power_off, .indication_q,
	.fault_out_q, .above_limit_output_q, .under_limit_output_q, .judgment_valid_q,
	.multi_band_sort_valid_q, .store_count_q);

// File: verification/ext_controller.sv
/*
 * external controller model: latches the port lines after each measurement.
 * assumes the lines settle one cycle after the done pulse.
 */
`timescale 1ns/10ps
module ext_controller (
	input  wire clk,
	input  wire srst,
	input  wire done_pulse,
	input  wire fault_line,
	input  wire above_line,
	input  wire under_line,
	output reg  seen_fault,
	output reg  seen_above,
	output reg  seen_under
);
reg done_q;
// a raised fault voids any judgment line, so those read as zero
always @(posedge clk) begin
	done_q <= done_pulse & ~srst;
	if (srst) begin
		{seen_fault, seen_above, seen_under} <= 3'h0;
	end else if (done_q) begin
		seen_fault <= fault_line;
		seen_above <= above_line & ~fault_line;
		seen_under <= under_line & ~fault_line;
	end
end
endmodule

// File: verification/testbench.sv
/*
 * self-checking bench for measurement_error_priority.
 * assumes the controller model and bound checker beside it.
 */
`timescale 1ns/10ps
`include "meas_err_map.vh"
module testbench;
reg clk, srst, meas_done, meas_start, adc_pos_overflow, adc_neg_overflow, cond_changed, contact_check_en;
reg temp_sensor_present, temp_over_range, temp_compensation_fault, contact_ok, comparator_en;
reg multi_band_sort_en, abs_judge_en, upper_limit_en, lower_limit_en;
reg signed [31:0] meas_value, range_upper, range_lower, temp_value, upper_limit, lower_limit;
reg [4:0] er;
reg [12:0] rd_index;
wire [2:0] indication_q;
wire [1:0] judgment_q;
wire fault_out_q, above_limit_output_q, under_limit_output_q, judgment_valid_q, multi_band_sort_valid_q;
wire temp_absent_q, seen_fault, seen_above, seen_under;
wire signed [31:0] value_out_q, temp_out_q, rd_data_q;
wire [12:0] store_count_q;
integer num_errors, check_count, i;
measurement_error_priority measurement_error_priority_i (.clk, .srst, .meas_done, .meas_value, .range_upper,
	.range_lower, .adc_pos_overflow, .adc_neg_overflow, .meas_start, .temp_sensor_present, .temp_over_range,
	.temp_value, .temp_compensation_fault, .contact_check_en, .contact_ok, .cond_changed, .comparator_en,
	.multi_band_sort_en, .abs_judge_en, .upper_limit_en, .lower_limit_en, .upper_limit, .lower_limit,
	.clear_record_key(er[0]), .panel_load(er[1]), .remote_clear(er[2]), .immediate_start(er[3]),
	.power_off(er[4]), .rd_index, .indication_q, .fault_out_q, .above_limit_output_q, .under_limit_output_q,
	.judgment_q, .judgment_valid_q, .multi_band_sort_valid_q, .value_out_q, .temp_out_q, .temp_absent_q,
	.store_count_q, .rd_data_q);
ext_controller ext_controller_i (.clk, .srst, .done_pulse(meas_done), .fault_line(fault_out_q),
	.above_line(above_limit_output_q), .under_line(under_limit_output_q), .seen_fault, .seen_above, .seen_under);
initial begin
	clk = 1'b0;
	forever #5 clk = ~clk;
end
task report_and_stop; begin
	if (num_errors == 0 && check_count > 0) $display("TEST PASSED");
	else $display("TEST FAILED");
	$finish;
end endtask
task chk(input [31:0] exp, input [31:0] got, input [8*8-1:0] nm); begin
	check_count = check_count + 1;
	if (got !== exp) begin
		num_errors = num_errors + 1;
		$display("[ERR] %0s expected %0h seen %0h", nm, exp, got);
	end
end endtask
// start, optional converter dip mid-run, done; returns once the controller has latched
task meas(input signed [31:0] v, input neg); begin
	@(posedge clk) meas_start <= 1'b1;
	@(posedge clk) meas_start <= 1'b0;
	adc_neg_overflow <= neg;
	@(posedge clk) adc_neg_overflow <= 1'b0;
	meas_value <= v;
	meas_done <= 1'b1;
	@(posedge clk) meas_done <= 1'b0;
	@(posedge clk) #1;
end endtask
task t_tc; begin
	temp_compensation_fault <= 1'b1;
	meas(13, 0);
	chk(`IND_TC_FAULT, indication_q, "ind");
	chk(0, above_limit_output_q, "above");
	chk(1, seen_fault, "seen_flt");
	temp_compensation_fault <= 1'b0;
end endtask
task t_over; begin
	meas(13, 0);
	chk(`IND_POS_OVR, indication_q, "ind");
	chk(`JUDGE_HI, judgment_q, "judge");
	chk(1, seen_above, "seen_abv");
	meas(5, 1);
	chk(`IND_NEG_OVR, indication_q, "ind");
	chk(`JUDGE_LO, judgment_q, "judge");
	chk(1, seen_under, "seen_und");
end endtask
task t_temp; begin
	temp_sensor_present <= 1'b1;
	temp_over_range <= 1'b1;
	meas(5, 0);
	chk(`IND_POS_OVR, indication_q, "ind");
	temp_sensor_present <= 1'b0;
	meas(5, 0);
	chk(`IND_NONE, indication_q, "ind");
	chk(1, temp_absent_q, "absent");
	temp_over_range <= 1'b0;
end endtask
task t_contact; begin
	contact_ok <= 1'b0;
	meas(5, 0);
	chk(`IND_CONTACT, indication_q, "ind");
	chk(0, judgment_valid_q, "valid");
	chk(1, seen_fault, "seen_flt");
	contact_ok <= 1'b1;
end endtask
task t_modes; begin
	abs_judge_en <= 1'b1;
	temp_sensor_present <= 1'b1;
	temp_value <= 32'sd42;
	meas(-9, 0);
	chk(`JUDGE_HI, judgment_q, "judge");
	chk(42, temp_out_q, "temp");
	meas(5, 1);
	chk(`JUDGE_HI, judgment_q, "judge");
	abs_judge_en <= 1'b0;
	upper_limit_en <= 1'b0;
	adc_pos_overflow <= 1'b1;
	meas(5, 0);
	chk(`IND_POS_OVR, indication_q, "ind");
	chk(`JUDGE_IN, judgment_q, "judge");
	chk(0, seen_above, "seen_abv");
	adc_pos_overflow <= 1'b0;
	upper_limit_en <= 1'b1;
	comparator_en <= 1'b0;
	multi_band_sort_en <= 1'b1;
	meas(5, 0);
	chk(1, multi_band_sort_valid_q, "band_ok");
	chk(0, judgment_valid_q, "valid");
	contact_ok <= 1'b0;
	meas(5, 0);
	chk(0, multi_band_sort_valid_q, "band_ok");
	contact_ok <= 1'b1;
	multi_band_sort_en <= 1'b0;
	comparator_en <= 1'b1;
	temp_sensor_present <= 1'b0;
end endtask
task t_normal; begin
	meas(5, 0);
	chk(`IND_NONE, indication_q, "ind");
	chk(`JUDGE_IN, judgment_q, "judge");
	chk(1, judgment_valid_q, "valid");
	chk(5, value_out_q, "value");
end endtask
task t_store; begin
	@(posedge clk) er <= 5'h01;
	@(posedge clk) er <= 5'h00;
	meas(3, 0);
	chk(1, store_count_q, "count");
	for (i = 1; i <= 5000; i = i + 1) meas(i, 0);
	chk(5000, store_count_q, "count");
	@(posedge clk) rd_index <= 13'h0000;
	@(posedge clk);
	@(posedge clk) #1;
	chk(1, rd_data_q, "rd_data");
	for (i = 0; i < 5; i = i + 1) begin
		meas(7, 0);
		@(posedge clk) er <= 5'h01 << i;
		@(posedge clk) er <= 5'h00;
		@(posedge clk) #1;
		chk(0, store_count_q, "count");
	end
end endtask
task t_nodata; begin
	@(posedge clk) cond_changed <= 1'b1;
	meas_done <= 1'b1;
	@(posedge clk) cond_changed <= 1'b0;
	meas_done <= 1'b0;
	@(posedge clk) #1;
	chk(`IND_NO_DATA, indication_q, "ind");
	chk(0, judgment_valid_q, "valid");
	chk(0, store_count_q, "count");
end endtask
initial begin
	#400000;
	num_errors = num_errors + 1;
	report_and_stop;
end
initial begin
	{meas_done, meas_start, adc_pos_overflow, adc_neg_overflow, cond_changed, temp_sensor_present} = 6'h00;
	{temp_over_range, temp_compensation_fault, multi_band_sort_en, abs_judge_en, er} = 9'h000;
	{contact_check_en, contact_ok, comparator_en, upper_limit_en, lower_limit_en} = 5'h1f;
	{meas_value, temp_value, rd_index} = 77'h0;
	{range_upper, range_lower, upper_limit, lower_limit} = {32'sd10, -32'sd10, 32'sd8, -32'sd8};
	num_errors = 0;
	check_count = 0;
	srst = 1'b1;
	repeat (8) @(posedge clk);
	srst <= 1'b0;
	t_tc;
	t_over;
	t_temp;
	t_contact;
	t_normal;
	t_modes;
	t_store;
	t_nodata;
	report_and_stop;
end
endmodule
